//--- adc_calib_output_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_regs.svh"
module adc_calib_output_config_regs_bench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, result_ready, byte_valid, byte_ready, byte_last;
  logic [1:0] bresp, rresp, cal_sample_size;
  logic [3:0] wstrb = 4'hf;
  logic [2:0] gain_request = 3'h0, monitor_select, pga_gain;
  logic result_valid = 1'b0, clr = 1'b0, hold = 1'b0, slow = 1'b0;
  logic [15:0] result_data = 16'h0, offset_trim_value, gain_trim_value;
  logic [7:0] status_data = 8'h0, byte_data;
  logic timeout_enable, crc_enable, status_prefix_enable, analog_input_pins_open;
  int got_n, n_mismatch = 0, n_checks = 0;

  always #12.5 aclk = ~aclk;

  adc_cfg_bank #(.ADDR_W(12), .TMO_CYCLES(8)) DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .gain_request(gain_request), .result_valid(result_valid), .result_ready(result_ready),
    .result_data(result_data), .status_data(status_data), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .byte_data(byte_data), .byte_last(byte_last),
    .timeout_enable(timeout_enable), .crc_enable(crc_enable),
    .status_prefix_enable(status_prefix_enable), .monitor_select(monitor_select),
    .cal_sample_size(cal_sample_size), .offset_trim_value(offset_trim_value),
    .gain_trim_value(gain_trim_value), .pga_gain(pga_gain),
    .analog_input_pins_open(analog_input_pins_open));

  byte_sink sink (.aclk(aclk), .clr(clr), .hold(hold), .slow(slow), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_last(byte_last), .byte_ready(byte_ready), .got_n(got_n));

  // counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic hang(input string m);
    n_mismatch++;
    $display("BAD %0t no answer: %s", $time, m);
    close_out();
  endtask : hang

  // crc8 over one byte, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction : crc8

  // axi4-lite write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    n = 0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      if (++n > 64) hang("write");
    end
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    logic ha, hr;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    n = 0;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
      if (++n > 64) hang("read");
    end
  endtask : rd

  // offer one result and release it once taken
  task automatic send(input logic [15:0] res, input logic [7:0] st);
    int n;
    logic h;
    @(posedge aclk);
    clr <= 1'b1;
    result_data <= res;
    status_data <= st;
    result_valid <= 1'b1;
    h = 1'b0;
    n = 0;
    while (!h) begin
      @(negedge aclk);
      h = result_ready;
      @(posedge aclk);
      clr <= 1'b0;
      if (h) result_valid <= 1'b0;
      if (++n > 400) hang("result");
    end
  endtask : send

  // reset values of the bank and of its outputs
  task automatic regs_reset();
    logic [7:0] idx [0:6] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
    logic [7:0] ex [0:6] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
    logic [7:0] d;
    logic [1:0] r;
    chk({monitor_select, cal_sample_size, timeout_enable, crc_enable, status_prefix_enable},
      16'h10, "ctl outputs");
    chk(offset_trim_value, 16'h0000, "offset reset");
    chk(gain_trim_value, 16'h4000, "gain reset");
    for (int i = 0; i < 7; i++) begin
      rd(idx[i], d, r);
      chk(16'(d), 16'(ex[i]), "reset value");
    end
  endtask : regs_reset

  // trims read-write, reserved places stay zero, unmapped gets slverr
  task automatic regs_rw();
    logic [7:0] d;
    logic [1:0] r;
    wr(`OFFS_LO_IDX, 8'ha5, r);
    wr(`OFFS_HI_IDX, 8'h5a, r);
    wr(`GAIN_LO_IDX, 8'hc3, r);
    wr(`GAIN_HI_IDX, 8'h3c, r);
    chk(offset_trim_value, 16'h5aa5, "offset value");
    chk(gain_trim_value, 16'h3cc3, "gain value");
    rd(`OFFS_HI_IDX, d, r);
    chk(16'(d), 16'h005a, "offset high");
    rd(`GAIN_LO_IDX, d, r);
    chk(16'(d), 16'h00c3, "gain low");
    wr(`RSVD_A_IDX, 8'h00, r);
    chk(16'(r), 16'h0, "reserved write resp");
    wr(`RSVD_D_IDX, 8'h00, r);
    rd(`RSVD_D_IDX, d, r);
    chk(16'(d), 16'h0, "reserved read");
    wr(8'h30, 8'h11, r);
    chk(16'(r), 16'h2, "unmapped write");
    rd(8'h30, d, r);
    chk({r, 6'h0, d}, 16'h8000, "unmapped read");
  endtask : regs_rw

  // every combination of the three low control bits
  task automatic ctl_bits();
    logic [7:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      wr(`SYSCTL_IDX, {5'h02, i[2:0]}, r);
      rd(`SYSCTL_IDX, d, r);
      chk(16'(d), 16'(i + 8'h10), "ctl readback");
      chk(16'(timeout_enable), 16'(i[2]), "timeout bit");
      chk(16'(crc_enable), 16'(i[1]), "crc bit");
      chk(16'(status_prefix_enable), 16'(i[0]), "status bit");
    end
  endtask : ctl_bits

  // each monitor code: switches and effective gain
  task automatic monitors();
    logic [7:0] d;
    logic [1:0] r;
    @(posedge aclk);
    gain_request <= 3'h2;
    for (int m = 0; m < 8; m++) begin
      wr(`SYSCTL_IDX, {m[2:0], 5'h10}, r);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk(16'(monitor_select), 16'(m), "monitor field");
      chk(16'(analog_input_pins_open), 16'(m >= 1 && m <= 4), "switches");
      chk(16'(pga_gain), (m == 3 || m == 4) ? 16'h0 : 16'h2, "gain");
      rd(`BLKSTAT_IDX, d, r);
      chk(16'(d[4:2]), (m == 3 || m == 4) ? 16'h0 : 16'h2, "status gain");
    end
  endtask : monitors

  // one result framed with the given control bits, sink fast or slow
  task automatic frame(input logic [2:0] ctl, input logic [15:0] res, input logic sl);
    logic [7:0] ex [0:3];
    logic [7:0] c;
    logic [1:0] r;
    int ne, n;
    wr(`SYSCTL_IDX, {5'h02, ctl}, r);
    ne = 0;
    c = 8'h00;
    if (ctl[0]) ex[ne++] = 8'h9c;
    ex[ne++] = res[15:8];
    ex[ne++] = res[7:0];
    for (int i = 0; i < ne; i++) c = crc8(c, ex[i]);
    if (ctl[1]) ex[ne++] = c;
    slow <= sl;
    send(res, 8'h9c);
    n = 0;
    // the sink log clears on the edge send returns at, so look after it
    do begin
      @(posedge aclk);
      if (++n > 400) hang("frame");
    end while (got_n < ne);
    repeat (30) @(posedge aclk);
    chk(16'(got_n), 16'(ne), "frame length");
    for (int i = 0; i < ne; i++)
      chk(16'(sink.got_q[i]), {7'h0, i == ne - 1, ex[i]}, "frame byte");
  endtask : frame

  // stalled sink with timeout on: frame dropped and flagged
  task automatic drop();
    logic [7:0] d;
    logic [1:0] r;
    int n;
    wr(`SYSCTL_IDX, 8'h14, r);
    hold <= 1'b1;
    send(16'h1234, 8'h00);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (byte_valid === 1'b1 && n < 40);
    chk(16'(byte_valid), 16'h0, "stalled byte dropped");
    rd(`BLKSTAT_IDX, d, r);
    chk(16'(d[1]), 16'h1, "timeout flag");
    hold <= 1'b0;
    wr(`BLKSTAT_IDX, 8'h02, r);
    rd(`BLKSTAT_IDX, d, r);
    chk(16'(d[1]), 16'h0, "timeout flag cleared");
    chk(16'(got_n), 16'h0, "nothing delivered");
  endtask : drop

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    regs_reset();
    regs_rw();
    ctl_bits();
    monitors();
    frame(3'b011, 16'ha55a, 1'b0);
    frame(3'b010, 16'h8001, 1'b0);
    frame(3'b001, 16'h7ffe, 1'b1);
    frame(3'b000, 16'h0000, 1'b1);
    drop();
    close_out();
  end
endmodule : adc_calib_output_config_regs_bench
`default_nettype wire

//--- adc_cfg_bank.sv
// Contract
// - system control bit 2 turns the serial stall timeout on; reset off.
// - system control bit 1 appends one crc byte after each result.
// - crc covers the 16-bit result, plus status byte when it is sent.
// - system control bit 0 sends a status byte before the result.
// - mid-supply, temperature and supply monitors open all input switches.
// - supply monitor selections force amplifier gain to one.
// - reserved registers 0ah and 0dh read zero; software writes only 00h.
// - offset trim: low byte 0bh, high byte 0ch, both reset zero.
// - gain trim: low byte 0eh reset zero, high byte 0fh reset 40h.
// - three-bit monitor field selects off, mid, temp, supplies, burn-out.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_regs.svh"
module adc_cfg_bank import adc_cfg_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int TMO_CYCLES = `TMO_CYCLES
) (
  input wire logic aclk,                  // 40 mhz clock
  input wire logic aresetn,               // sync reset, low
  input wire logic [ADDR_W-1:0] awaddr,   // write address
  input wire logic [2:0] awprot,          // unused protection
  input wire logic awvalid,               // write address valid
  output logic awready,                   // write address ready
  input wire logic [31:0] wdata,          // write data
  input wire logic [3:0] wstrb,           // byte enables
  input wire logic wvalid,                // write data valid
  output logic wready,                    // write data ready
  output logic [1:0] bresp,               // write response
  output logic bvalid,                    // write response valid
  input wire logic bready,                // write response ready
  input wire logic [ADDR_W-1:0] araddr,   // read address
  input wire logic [2:0] arprot,          // unused protection
  input wire logic arvalid,               // read address valid
  output logic arready,                   // read address ready
  output logic [31:0] rdata,              // read data
  output logic [1:0] rresp,               // read response
  output logic rvalid,                    // read data valid
  input wire logic rready,                // read data ready
  input wire logic [2:0] gain_request,    // programmed gain code
  input wire logic result_valid,          // conversion result offered
  output logic result_ready,              // framer takes result
  input wire logic [15:0] result_data,    // conversion result
  input wire logic [7:0] status_data,     // status byte
  output logic byte_valid,                // output byte offered
  input wire logic byte_ready,            // output byte taken
  output logic [7:0] byte_data,           // output byte
  output logic byte_last,                 // last byte of frame
  output logic timeout_enable,            // stall timeout on
  output logic crc_enable,                // crc byte appended
  output logic status_prefix_enable,      // status byte prepended
  output logic [2:0] monitor_select,      // monitor selection
  output logic [1:0] cal_sample_size,     // calibration averaging code
  output logic [15:0] offset_trim_value,  // offset calibration
  output logic [15:0] gain_trim_value,    // gain calibration
  output logic [2:0] pga_gain,            // effective gain code
  output logic analog_input_pins_open     // all input switches open
);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [7:0] sys_q, sys_d, offl_q, offl_d, offh_q, offh_d;
  logic [7:0] gnl_q, gnl_d, gnh_q, gnh_d;
  logic [7:0] awidx_q, awidx_d, aridx;
  logic [31:0] wdat_q, wdat_d, rdata_q, rdata_d;
  logic [3:0] wstb_q, wstb_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic tmo_seen_q, tmo_seen_d, open_q, open_d;
  logic [2:0] gain_q, gain_d;
  logic do_write, ar_take, busy, tmo_pulse, wr_lane0, hit_w;
  monitor_t mon;

  assign mon = monitor_t'(sys_q[`SYS_MON_MSB:`SYS_MON_LSB]);
  assign aridx = araddr[9:2];
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign ar_take = arvalid && arrdy_q;
  assign wr_lane0 = do_write && wstb_q[0];

  // write channel capture, address and data in either order
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awidx_d = awidx_q;
    wdat_d = wdat_q;
    wstb_d = wstb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (awvalid && awrdy_q) begin
      aw_held_d = 1'b1;
      awidx_d = awaddr[9:2];
    end
    if (wvalid && wrdy_q) begin
      w_held_d = 1'b1;
      wdat_d = wdata;
      wstb_d = wstrb;
    end
    hit_w = 1'b1;
    unique case (awidx_q)
      `SYSCTL_IDX, `RSVD_A_IDX, `OFFS_LO_IDX, `OFFS_HI_IDX,
      `RSVD_D_IDX, `GAIN_LO_IDX, `GAIN_HI_IDX, `BLKSTAT_IDX: hit_w = 1'b1;
      default: hit_w = 1'b0;
    endcase
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = hit_w ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    awrdy_d = !aw_held_d;
    wrdy_d = !w_held_d;
  end

  // register file writes, reserved words drop the write
  always_comb begin
    sys_d = sys_q;
    offl_d = offl_q;
    offh_d = offh_q;
    gnl_d = gnl_q;
    gnh_d = gnh_q;
    tmo_seen_d = tmo_seen_q;
    if (wr_lane0) begin
      unique case (awidx_q)
        `SYSCTL_IDX: sys_d = wdat_q[7:0];
        `OFFS_LO_IDX: offl_d = wdat_q[7:0];
        `OFFS_HI_IDX: offh_d = wdat_q[7:0];
        `GAIN_LO_IDX: gnl_d = wdat_q[7:0];
        `GAIN_HI_IDX: gnh_d = wdat_q[7:0];
        `BLKSTAT_IDX: if (wdat_q[`BST_TMO_BIT]) tmo_seen_d = 1'b0;
        default: ;
      endcase
    end
    // a timeout in the clearing cycle still sets the flag
    if (tmo_pulse) tmo_seen_d = 1'b1;
  end

  // read channel
  always_comb begin
    arrdy_d = arrdy_q || !rvalid_q; // ready again once idle
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_take) begin
      arrdy_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case (aridx)
        `SYSCTL_IDX: rdata_d[7:0] = sys_q;
        `RSVD_A_IDX, `RSVD_D_IDX: rdata_d[7:0] = 8'h00;
        `OFFS_LO_IDX: rdata_d[7:0] = offl_q;
        `OFFS_HI_IDX: rdata_d[7:0] = offh_q;
        `GAIN_LO_IDX: rdata_d[7:0] = gnl_q;
        `GAIN_HI_IDX: rdata_d[7:0] = gnh_q;
        `BLKSTAT_IDX: begin
          rdata_d[`BST_BUSY_BIT] = busy;
          rdata_d[`BST_TMO_BIT] = tmo_seen_q;
          rdata_d[`BST_GAIN_MSB:`BST_GAIN_LSB] = gain_q;
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
      arrdy_d = 1'b1;
    end
  end

  // analog side effects of the monitor selection
  always_comb begin
    gain_d = gain_request;
    open_d = 1'b0;
    unique case (mon)
      MON_MID, MON_TEMP: open_d = 1'b1;
      MON_AVDD, MON_DVDD: begin
        open_d = 1'b1;
        gain_d = `GAIN_UNITY;
      end
      MON_OFF, MON_BO_LO, MON_BO_MID, MON_BO_HI: ;
    endcase
  end

  // one register stage for all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_q <= `SYSCTL_RST;
      offl_q <= `OFFS_LO_RST;
      offh_q <= `OFFS_HI_RST;
      gnl_q <= `GAIN_LO_RST;
      gnh_q <= `GAIN_HI_RST;
      awidx_q <= 8'h00;
      wdat_q <= 32'h0000_0000;
      wstb_q <= 4'h0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awrdy_q <= 1'b0;
      wrdy_q <= 1'b0;
      arrdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      tmo_seen_q <= 1'b0;
      gain_q <= `GAIN_UNITY;
      open_q <= 1'b0;
    end else begin
      sys_q <= sys_d;
      offl_q <= offl_d;
      offh_q <= offh_d;
      gnl_q <= gnl_d;
      gnh_q <= gnh_d;
      awidx_q <= awidx_d;
      wdat_q <= wdat_d;
      wstb_q <= wstb_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      arrdy_q <= arrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      tmo_seen_q <= tmo_seen_d;
      gain_q <= gain_d;
      open_q <= open_d;
    end
  end

  // conversion result framer
  result_framer #(.TMO_CYCLES(TMO_CYCLES)) u_framer (
    .aclk(aclk),
    .aresetn(aresetn),
    .result_valid(result_valid),
    .result_ready(result_ready),
    .result_data(result_data),
    .status_data(status_data),
    .stat_en(sys_q[`SYS_STAT_BIT]),
    .crc_en(sys_q[`SYS_CRC_BIT]),
    .tmo_en(sys_q[`SYS_TMO_BIT]),
    .byte_valid(byte_valid),
    .byte_ready(byte_ready),
    .byte_data(byte_data),
    .byte_last(byte_last),
    .busy(busy),
    .tmo_pulse(tmo_pulse)
  );

  // register-driven outputs
  assign awready = awrdy_q;
  assign wready = wrdy_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arrdy_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign timeout_enable = sys_q[`SYS_TMO_BIT];
  assign crc_enable = sys_q[`SYS_CRC_BIT];
  assign status_prefix_enable = sys_q[`SYS_STAT_BIT];
  assign monitor_select = sys_q[`SYS_MON_MSB:`SYS_MON_LSB];
  assign cal_sample_size = sys_q[`SYS_CAL_MSB:`SYS_CAL_LSB];
  assign offset_trim_value = {offh_q, offl_q};
  assign gain_trim_value = {gnh_q, gnl_q};
  assign pga_gain = gain_q;
  assign analog_input_pins_open = open_q;

  sequence s_sys_write;
    do_write && wstb_q[0] && awidx_q == `SYSCTL_IDX;
  endsequence

  a_timeout_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sys_write |=> timeout_enable == $past(wdat_q[2]))
    else $error("timeout enable did not follow write");
  a_crc_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sys_write |=> crc_enable == $past(wdat_q[1]))
    else $error("crc enable did not follow write");
  a_status_prefix: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_prefix_enable && result_valid && result_ready)
      |=> byte_valid && byte_data == $past(status_data))
    else $error("status byte not sent first");
  a_switch_open: assert property (@(posedge aclk) disable iff (!aresetn)
    (mon inside {MON_MID, MON_TEMP, MON_AVDD, MON_DVDD}) |=> analog_input_pins_open)
    else $error("input switches not opened for monitor");
  a_gain_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    (mon == MON_AVDD || mon == MON_DVDD) |=> pga_gain == 3'h0)
    else $error("supply monitor gain not unity");
  a_temp_gain_user: assert property (@(posedge aclk) disable iff (!aresetn)
    (mon == MON_TEMP) |=> pga_gain == $past(gain_request) && analog_input_pins_open)
    else $error("temperature gain not user gain");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && (aridx == `RSVD_A_IDX || aridx == `RSVD_D_IDX))
      |=> rvalid && rdata == 32'h0 && rresp == 2'h0)
    else $error("reserved register not read as zero");
  a_trim_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> offset_trim_value == 16'h0000 && gain_trim_value == 16'h4000)
    else $error("trim values wrong after reset");
  a_gain_hi_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wstb_q[0] && awidx_q == `GAIN_HI_IDX) |=> gain_trim_value[15:8] == $past(wdat_q[7:0]))
    else $error("gain trim high not written");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid && bresp == ($past(hit_w) ? 2'h0 : 2'h2))
    else $error("no write response after write");
endmodule : adc_cfg_bank
`default_nettype wire

//--- adc_cfg_pkg.sv
package adc_cfg_pkg;

  // system monitor selections
  typedef enum logic [2:0] {
    MON_OFF = 3'h0,
    MON_MID = 3'h1,
    MON_TEMP = 3'h2,
    MON_AVDD = 3'h3,
    MON_DVDD = 3'h4,
    MON_BO_LO = 3'h5,
    MON_BO_MID = 3'h6,
    MON_BO_HI = 3'h7
  } monitor_t;

  // output frame sequencer states
  typedef enum logic [4:0] {
    FS_IDLE = 5'b00001,
    FS_STAT = 5'b00010,
    FS_MSB = 5'b00100,
    FS_LSB = 5'b01000,
    FS_CRC = 5'b10000
  } frame_state_t;

endpackage : adc_cfg_pkg

//--- adc_cfg_regs.svh
`ifndef ADC_CFG_REGS_SVH
`define ADC_CFG_REGS_SVH

// register indexes, byte address is four times the index
`define SYSCTL_IDX 8'h09
`define RSVD_A_IDX 8'h0a
`define OFFS_LO_IDX 8'h0b
`define OFFS_HI_IDX 8'h0c
`define RSVD_D_IDX 8'h0d
`define GAIN_LO_IDX 8'h0e
`define GAIN_HI_IDX 8'h0f
`define BLKSTAT_IDX 8'h20

// reset values
`define SYSCTL_RST 8'h10
`define OFFS_LO_RST 8'h00
`define OFFS_HI_RST 8'h00
`define GAIN_LO_RST 8'h00
`define GAIN_HI_RST 8'h40

// system control fields
`define SYS_STAT_BIT 0
`define SYS_CRC_BIT 1
`define SYS_TMO_BIT 2
`define SYS_CAL_LSB 3
`define SYS_CAL_MSB 4
`define SYS_MON_LSB 5
`define SYS_MON_MSB 7

// block status fields
`define BST_BUSY_BIT 0
`define BST_TMO_BIT 1
`define BST_GAIN_LSB 2
`define BST_GAIN_MSB 4

// timing and coding
`define TMO_CYCLES 4096
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define GAIN_UNITY 3'h0

`endif

//--- byte_sink.sv
`timescale 1ns/1ps
`default_nettype none
module byte_sink (
  input wire logic aclk,            // clock
  input wire logic clr,             // empty the capture log
  input wire logic hold,            // never take a byte
  input wire logic slow,            // take one byte every twelve cycles
  input wire logic byte_valid,      // byte offered
  input wire logic [7:0] byte_data, // byte payload
  input wire logic byte_last,       // last byte of frame
  output logic byte_ready,          // byte taken
  output int got_n                  // bytes captured
);
  logic [8:0] got_q [0:7];
  logic [3:0] pace_q;
  // quiet start so the design never sees an unknown ready
  initial begin
    byte_ready = 1'b0;
    got_n = 0;
    pace_q = 4'h0;
  end
  // pace ready after each edge and log each taken byte, up to eight, with its last flag
  always @(posedge aclk) begin
    pace_q <= (pace_q == 4'hb) ? 4'h0 : pace_q + 4'h1;
    byte_ready <= !hold && (!slow || pace_q == 4'hb);
    if (clr) begin
      got_n <= 0;
    end else if (byte_valid && byte_ready && got_n < 8) begin
      got_q[got_n] <= {byte_last, byte_data};
      got_n <= got_n + 1;
    end
  end
endmodule : byte_sink
`default_nettype wire

//--- crc8_step.sv
`timescale 1ns/1ps
`default_nettype none
module crc8_step #(
  parameter logic [7:0] POLY = 8'h07
) (
  input wire logic [7:0] crc_in,  // running remainder
  input wire logic [7:0] data_in, // byte folded in, msb first
  output logic [7:0] crc_out      // updated remainder
);
  // bitwise msb-first division of one byte
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
    end
    crc_out = c;
  end
endmodule : crc8_step
`default_nettype wire

//--- result_framer.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_regs.svh"
module result_framer import adc_cfg_pkg::*; #(
  parameter int TMO_CYCLES = `TMO_CYCLES
) (
  input wire logic aclk,               // clock
  input wire logic aresetn,            // sync reset, low
  input wire logic result_valid,       // conversion result offered
  output logic result_ready,           // framer idle, takes result
  input wire logic [15:0] result_data, // conversion result
  input wire logic [7:0] status_data,  // status byte
  input wire logic stat_en,            // prefix status byte
  input wire logic crc_en,             // append crc byte
  input wire logic tmo_en,             // stall timeout on
  output logic byte_valid,             // byte offered
  input wire logic byte_ready,         // byte taken
  output logic [7:0] byte_data,        // byte payload
  output logic byte_last,              // last byte of frame
  output logic busy,                   // frame under way
  output logic tmo_pulse               // frame abandoned
);
  frame_state_t state_q, state_d;
  logic [15:0] res_q, res_d;
  logic [7:0] crc_q, crc_d, crc_nxt, data_q, data_d;
  logic crc_on_q, crc_on_d, valid_q, valid_d, last_q, last_d, rdy_q, rdy_d;
  logic tmo_q, tmo_d;
  logic [15:0] cnt_q, cnt_d;
  logic take;

  crc8_step #(.POLY(`CRC_POLY)) u_crc (
    .crc_in(crc_q),
    .data_in(data_q),
    .crc_out(crc_nxt)
  );

  assign take = valid_q && byte_ready;

  // byte sequencing: status, msb, lsb, crc
  always_comb begin
    state_d = state_q;
    res_d = res_q;
    crc_d = crc_q;
    data_d = data_q;
    crc_on_d = crc_on_q;
    valid_d = valid_q;
    last_d = last_q;
    tmo_d = 1'b0;
    cnt_d = (valid_q && !byte_ready && tmo_en) ? cnt_q + 16'h0001 : 16'h0000;
    unique case (state_q)
      FS_IDLE: begin
        if (result_valid && rdy_q) begin
          res_d = result_data;
          crc_d = `CRC_INIT;
          crc_on_d = crc_en;
          valid_d = 1'b1;
          last_d = 1'b0;
          state_d = stat_en ? FS_STAT : FS_MSB;
          data_d = stat_en ? status_data : result_data[15:8];
        end
      end
      FS_STAT: if (take) begin
        crc_d = crc_nxt;
        data_d = res_q[15:8];
        state_d = FS_MSB;
      end
      FS_MSB: if (take) begin
        crc_d = crc_nxt;
        data_d = res_q[7:0];
        last_d = !crc_on_q;
        state_d = FS_LSB;
      end
      FS_LSB: if (take) begin
        crc_d = crc_nxt;
        if (crc_on_q) begin
          data_d = crc_nxt;
          last_d = 1'b1;
          state_d = FS_CRC;
        end else begin
          valid_d = 1'b0;
          state_d = FS_IDLE;
        end
      end
      FS_CRC: if (take) begin
        valid_d = 1'b0;
        last_d = 1'b0;
        state_d = FS_IDLE;
      end
    endcase
    // stalled too long: drop the frame
    if (state_q != FS_IDLE && tmo_en && cnt_q == 16'(TMO_CYCLES - 1) && !take) begin
      valid_d = 1'b0;
      last_d = 1'b0;
      tmo_d = 1'b1;
      state_d = FS_IDLE;
      cnt_d = 16'h0000;
    end
    rdy_d = (state_d == FS_IDLE);
  end

  // register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= FS_IDLE;
      res_q <= 16'h0000;
      crc_q <= `CRC_INIT;
      data_q <= 8'h00;
      crc_on_q <= 1'b0;
      valid_q <= 1'b0;
      last_q <= 1'b0;
      rdy_q <= 1'b0;
      tmo_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      res_q <= res_d;
      crc_q <= crc_d;
      data_q <= data_d;
      crc_on_q <= crc_on_d;
      valid_q <= valid_d;
      last_q <= last_d;
      rdy_q <= rdy_d;
      tmo_q <= tmo_d;
      cnt_q <= cnt_d;
    end
  end

  assign result_ready = rdy_q;
  assign byte_valid = valid_q;
  assign byte_data = data_q;
  assign byte_last = last_q;
  assign busy = !rdy_q;
  assign tmo_pulse = tmo_q;

  a_crc_last: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == FS_LSB && take && crc_on_q) |=> byte_valid && byte_last && byte_data == $past(crc_nxt))
    else $error("crc byte not appended after lsb");
endmodule : result_framer
`default_nettype wire
